// [eqf_regs.svh]
// Purpose: Register map and field constants of the equalizer FIR block
// Assumes: Word-aligned APB, byte address is four times the index
// Notes:   Definitions only, included by eqf_top and the bench
`ifndef EQF_REGS_SVH
`define EQF_REGS_SVH

// Register indices, channel A set (byte address = index * 4)
`define EQF_IDX_A_TAP1   14'h0418
`define EQF_IDX_A_TAP2   14'h041A
`define EQF_IDX_A_TAP3   14'h041C
`define EQF_IDX_A_TAP4   14'h041E
`define EQF_IDX_A_CENTER 14'h0420
`define EQF_IDX_A_TAP6   14'h0423
`define EQF_IDX_A_TAP7   14'h0425
`define EQF_IDX_A_TAP8   14'h0427
`define EQF_IDX_A_TAP9   14'h0429
// Register indices, channel B set
`define EQF_IDX_B_TAP1   14'h0448
`define EQF_IDX_B_TAP2   14'h044A
`define EQF_IDX_B_TAP3   14'h044C
`define EQF_IDX_B_TAP4   14'h044E
`define EQF_IDX_B_CENTER 14'h0450
`define EQF_IDX_B_TAP6   14'h0453
`define EQF_IDX_B_TAP7   14'h0455
`define EQF_IDX_B_TAP8   14'h0457
`define EQF_IDX_B_TAP9   14'h0459
// Control and status
`define EQF_IDX_CTRL     14'h0430
`define EQF_IDX_STAT     14'h0431

// Field layout
`define EQF_CENTER_TAP   4'h4
`define EQF_TAP_MSB      11
`define EQF_CENTER_MSB   17
`define EQF_TAP_MASK     24'h00FFFF
`define EQF_CENTER_MASK  24'hFFFFFF
`define EQF_CTRL_SINGLE  0
`define EQF_COEF_RST     24'h000000
`define EQF_CTRL_RST     1'h0

`endif

// [eqf_pkg.sv]
// Purpose: Types shared by the equalizer FIR block
// Assumes: Constants live in eqf_regs.svh
// Notes:   Structs carry the APB groups and the sample streams
package eqf_pkg;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } eqf_apb_req_type;

    // APB answer to the master
    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } eqf_apb_rsp_type;

    // Input sample with its strobe
    typedef struct packed {
        logic               valid;
        logic signed [7:0]  data;
    } eqf_smp_type;

    // Filtered sample with its strobe
    typedef struct packed {
        logic               valid;
        logic signed [31:0] data;
    } eqf_acc_type;

    // One coefficient, widest field sign-extended to 18 bits
    typedef logic signed [17:0] eqf_coef_type;
    typedef eqf_coef_type [8:0] eqf_coef_vec_type;

    // Converter channel mode
    typedef enum logic {
        EQF_DUAL   = 1'b0,
        EQF_SINGLE = 1'b1
    } eqf_mode_type;

    // Result of an address decode
    typedef struct packed {
        logic       hit;
        logic       chan_b;
        logic [3:0] tap;
    } eqf_dec_type;

endpackage : eqf_pkg

// [eqf_apb_slave.sv]
// Purpose: APB protocol shell, zero wait states
// Assumes: Register decode and read mux sit in the parent
// Notes:   Read data is caught in the setup cycle so prdata is a flop
`timescale 1ns/1ps
module eqf_apb_slave
    import eqf_pkg::*;
(
    // Clock and reset
    input  logic            clock_i,
    input  logic            rst_n_i,
    // APB
    input  eqf_apb_req_type apb_i,
    output eqf_apb_rsp_type apb_o,
    // Register side
    input  logic [31:0]     rd_data_i,
    input  logic            hit_i,
    output logic            wr_stb_o
);

    logic        setup;    // Setup cycle of a transfer
    logic [31:0] rd_q;     // Read data held for the access phase
    logic        err_q;    // Unmapped or misaligned address

    assign setup = apb_i.psel & ~apb_i.penable;

    // Capture answer at setup; the request is stable until access ends
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q  <= 32'h00000000;
            err_q <= 1'b0;
        end else if (setup) begin
            rd_q  <= (hit_i && !apb_i.pwrite) ? rd_data_i : 32'h00000000;
            err_q <= ~hit_i | (apb_i.paddr[1:0] != 2'h0);
        end
    end

    // Never stalls, so every access phase completes at once
    assign apb_o.pready  = 1'b1;
    assign apb_o.prdata  = rd_q;
    assign apb_o.pslverr = apb_i.psel & apb_i.penable & err_q;
    // Erroring writes are dropped so an odd address cannot alias
    assign wr_stb_o = apb_i.psel & apb_i.penable & apb_i.pwrite & ~err_q;

endmodule : eqf_apb_slave

// [eqf_fir_core.sv]
// Purpose: Nine-tap direct-form FIR for one channel
// Assumes: Coefficients arrive sign-extended to 18 bits
// Notes:   One output per input strobe, one cycle later
`timescale 1ns/1ps
module eqf_fir_core
    import eqf_pkg::*;
(
    // Clock and reset
    input  logic             clock_i,
    input  logic             rst_n_i,
    // Stream
    input  eqf_smp_type      smp_i,
    output eqf_acc_type      acc_o,
    // Coefficients, tap 1 at index 0
    input  eqf_coef_vec_type coef_i
);

    logic [7:0][7:0] line;      // Delayed samples, newest at index 0
    logic [8:0][7:0] next_line; // Window including the new sample

    // Sum of products; 32 bits leave ample headroom over 26-bit terms
    function automatic logic signed [31:0] eqf_dot(
        input eqf_coef_vec_type c,
        input logic [8:0][7:0]  x
    );
        logic signed [31:0] s;
        s = 32'sh00000000;
        for (int k = 0; k < 9; k++) begin
            s = s + 32'(c[k] * $signed(x[k]));
        end
        return s;
    endfunction : eqf_dot

    assign next_line = {line, smp_i.data};

    // Shift the delay line on each accepted sample
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line <= '0;
        end else if (smp_i.valid) begin
            line <= next_line[7:0];
        end
    end

    // Registered output and strobe
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_o <= '0;
        end else begin
            acc_o.valid <= smp_i.valid;
            if (smp_i.valid) begin
                acc_o.data <= eqf_dot(coef_i, next_line);
            end
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    out_strobe_a: assert property (smp_i.valid |=> acc_o.valid)
        else $error("filter output strobe missing");

endmodule : eqf_fir_core

// [eqf_top.sv]
// Purpose: Equalizer FIR coefficient store and two channel filters
// Assumes: APB master on clock_i, samples from logic on clock_i
// Notes:   Single mode drives both filters from the channel A set
`timescale 1ns/1ps
`include "eqf_regs.svh"

module eqf_top
    import eqf_pkg::*;
(
    // Clock and reset
    input  logic            clock_i,
    input  logic            rst_n_i,
    // APB register port
    input  eqf_apb_req_type apb_i,
    output eqf_apb_rsp_type apb_o,
    // Channel A stream (whole stream in single mode)
    input  eqf_smp_type     smp_a_i,
    output eqf_acc_type     acc_a_o,
    // Channel B stream
    input  eqf_smp_type     smp_b_i,
    output eqf_acc_type     acc_b_o,
    // Mode seen by the rest of the converter
    output eqf_mode_type    mode_o
);

    logic [23:0]      coef_a [0:8]; // Channel A register images
    logic [23:0]      coef_b [0:8]; // Channel B register images
    eqf_mode_type     mode;         // Dual or single channel
    eqf_dec_type      dec;          // Decode of the current address
    logic [13:0]      idx;          // Word index of the current address
    logic             ctrl_hit;     // Control register addressed
    logic             stat_hit;     // Status register addressed
    logic [31:0]      rd_data;      // Read mux output
    logic             wr_stb;       // Write takes effect this edge
    eqf_coef_vec_type a_vec;        // Signed coefficients, set A
    eqf_coef_vec_type b_vec;        // Signed coefficients, set B
    eqf_coef_vec_type b_use;        // Coefficients for the B filter

    // Map a word index onto a set and a tap position
    function automatic eqf_dec_type eqf_decode(input logic [13:0] i);
        eqf_dec_type d;
        d = '{hit: 1'b1, chan_b: 1'b0, tap: 4'h0};
        case (i)
            `EQF_IDX_A_TAP1:   d.tap = 4'h0;
            `EQF_IDX_A_TAP2:   d.tap = 4'h1;
            `EQF_IDX_A_TAP3:   d.tap = 4'h2;
            `EQF_IDX_A_TAP4:   d.tap = 4'h3;
            `EQF_IDX_A_CENTER: d.tap = `EQF_CENTER_TAP;
            `EQF_IDX_A_TAP6:   d.tap = 4'h5;
            `EQF_IDX_A_TAP7:   d.tap = 4'h6;
            `EQF_IDX_A_TAP8:   d.tap = 4'h7;
            `EQF_IDX_A_TAP9:   d.tap = 4'h8;
            `EQF_IDX_B_TAP1:   d = '{1'b1, 1'b1, 4'h0};
            `EQF_IDX_B_TAP2:   d = '{1'b1, 1'b1, 4'h1};
            `EQF_IDX_B_TAP3:   d = '{1'b1, 1'b1, 4'h2};
            `EQF_IDX_B_TAP4:   d = '{1'b1, 1'b1, 4'h3};
            `EQF_IDX_B_CENTER: d = '{1'b1, 1'b1, `EQF_CENTER_TAP};
            `EQF_IDX_B_TAP6:   d = '{1'b1, 1'b1, 4'h5};
            `EQF_IDX_B_TAP7:   d = '{1'b1, 1'b1, 4'h6};
            `EQF_IDX_B_TAP8:   d = '{1'b1, 1'b1, 4'h7};
            `EQF_IDX_B_TAP9:   d = '{1'b1, 1'b1, 4'h8};
            default:           d.hit = 1'b0;
        endcase
        return d;
    endfunction : eqf_decode

    // Writable bits of a coefficient register; reserved bits are R/W
    function automatic logic [23:0] eqf_mask(input logic [3:0] tap);
        return (tap == `EQF_CENTER_TAP) ? `EQF_CENTER_MASK
                                        : `EQF_TAP_MASK;
    endfunction : eqf_mask

    // Signed value the filter sees; reserved bits never reach it
    function automatic eqf_coef_type eqf_field(
        input logic [23:0] r,
        input int          k
    );
        if (k == int'(`EQF_CENTER_TAP)) begin
            return $signed(r[`EQF_CENTER_MSB:0]);
        end
        return 18'($signed(r[`EQF_TAP_MSB:0]));
    endfunction : eqf_field

    // Address decode shared by the read mux and the write path
    assign idx      = apb_i.paddr[15:2];
    assign dec      = eqf_decode(idx);
    assign ctrl_hit = (idx == `EQF_IDX_CTRL);
    assign stat_hit = (idx == `EQF_IDX_STAT);

    // Read mux; narrow registers read zero above their width
    always_comb begin
        rd_data = 32'h00000000;
        if (dec.hit) begin
            rd_data = dec.chan_b ? {8'h00, coef_b[dec.tap]}
                                 : {8'h00, coef_a[dec.tap]};
        end else if (ctrl_hit) begin
            rd_data = {31'h00000000, mode};
        end else if (stat_hit) begin
            rd_data = acc_a_o.data;
        end
    end

    // Bus protocol shell
    eqf_apb_slave u_apb (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .apb_i     (apb_i),
        .apb_o     (apb_o),
        .rd_data_i (rd_data),
        .hit_i     (dec.hit | ctrl_hit | stat_hit),
        .wr_stb_o  (wr_stb)
    );

    // Coefficient registers; all clear at reset so the filter is silent
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int k = 0; k < 9; k++) begin
                coef_a[k] <= `EQF_COEF_RST;
                coef_b[k] <= `EQF_COEF_RST;
            end
        end else if (wr_stb && dec.hit) begin
            if (dec.chan_b) begin
                coef_b[dec.tap] <= apb_i.pwdata[23:0] & eqf_mask(dec.tap);
            end else begin
                coef_a[dec.tap] <= apb_i.pwdata[23:0] & eqf_mask(dec.tap);
            end
        end
    end

    // Mode register; the status word is read-only and ignores writes
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode <= eqf_mode_type'(`EQF_CTRL_RST);
        end else if (wr_stb && ctrl_hit) begin
            mode <= eqf_mode_type'(apb_i.pwdata[`EQF_CTRL_SINGLE]);
        end
    end

    assign mode_o = mode;

    // Tap assignment: index k drives tap k+1 of each filter
    always_comb begin
        for (int k = 0; k < 9; k++) begin
            a_vec[k] = eqf_field(coef_a[k], k);
            b_vec[k] = eqf_field(coef_b[k], k);
        end
    end

    // Single mode has one filter, so both halves take set A
    assign b_use = (mode == EQF_SINGLE) ? a_vec : b_vec;

    // Channel A filter, also the shared filter in single mode
    eqf_fir_core u_fir_a (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .smp_i   (smp_a_i),
        .acc_o   (acc_a_o),
        .coef_i  (a_vec)
    );

    // Channel B filter; its own set only in dual mode
    eqf_fir_core u_fir_b (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .smp_i   (smp_b_i),
        .acc_o   (acc_b_o),
        .coef_i  (b_use)
    );

    // Checks on the register file and the tap assignment
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    logic a_wr; // Write into set A this edge
    assign a_wr = wr_stb & dec.hit & ~dec.chan_b;

    center_sign_a: assert property (
        (a_wr && idx == `EQF_IDX_A_CENTER)
        |=> a_vec[4] == $signed($past(apb_i.pwdata[17:0])))
        else $error("center tap not 18-bit signed");

    tap_sign_a: assert property (
        (a_wr && idx == `EQF_IDX_A_TAP6)
        |=> a_vec[5] == 18'($signed($past(apb_i.pwdata[11:0]))))
        else $error("outer tap not 12-bit signed");

    center_pos_a: assert property (
        (a_wr && idx == `EQF_IDX_A_CENTER)
        |=> coef_a[4] == $past(apb_i.pwdata[23:0]))
        else $error("center write missed tap five");

    tap_six_a: assert property (
        (a_wr && idx == `EQF_IDX_A_TAP6)
        |=> coef_a[5] == {8'h00, $past(apb_i.pwdata[15:0])})
        else $error("tap six write misplaced");

    tap_seven_a: assert property (
        (a_wr && idx == `EQF_IDX_A_TAP7)
        |=> coef_a[6] == {8'h00, $past(apb_i.pwdata[15:0])})
        else $error("tap seven write misplaced");

    tap_eight_a: assert property (
        (a_wr && idx == `EQF_IDX_A_TAP8)
        |=> coef_a[7] == {8'h00, $past(apb_i.pwdata[15:0])})
        else $error("tap eight write misplaced");

    tap_nine_a: assert property (
        (a_wr && idx == `EQF_IDX_A_TAP9)
        |=> coef_a[8] == {8'h00, $past(apb_i.pwdata[15:0])})
        else $error("tap nine write misplaced");

    shared_set_a: assert property (
        (mode == EQF_SINGLE) |-> (b_use == a_vec))
        else $error("single mode not sharing set A");

    low_taps_a: assert property (
        (a_wr && idx == `EQF_IDX_A_TAP1)
        |=> a_vec[0] == 18'($signed($past(apb_i.pwdata[11:0]))))
        else $error("tap one write misplaced");

    set_b_apart_a: assert property (
        (wr_stb && dec.hit && dec.chan_b && mode == EQF_DUAL)
        |=> $stable(a_vec) && b_use == b_vec)
        else $error("set B write disturbed set A");

    zero_out_a: assert property (
        (smp_a_i.valid && a_vec == '0) |=> acc_a_o.data == 32'h00000000)
        else $error("zero coefficients gave nonzero output");

    // Helpers for the bus-side checks below
    logic a_rd; // Setup cycle of a read from set A
    logic b_wr; // Write into set B this edge
    assign a_rd = apb_i.psel & ~apb_i.penable & ~apb_i.pwrite
                & dec.hit & ~dec.chan_b;
    assign b_wr = wr_stb & dec.hit & dec.chan_b;

    // Every outer tap keeps its own 12-bit sign, not only tap six
    tap_seven_sign_a: assert property (
        (a_wr && idx == `EQF_IDX_A_TAP7)
        |=> a_vec[6] == 18'($signed($past(apb_i.pwdata[11:0]))))
        else $error("tap seven not 12-bit signed");

    // Tap eight: reserved bits 15:12 must not leak into the sign
    tap_eight_sign_a: assert property (
        (a_wr && idx == `EQF_IDX_A_TAP8)
        |=> a_vec[7] == 18'($signed($past(apb_i.pwdata[11:0]))))
        else $error("tap eight not 12-bit signed");

    // Last tap of the line, same field layout as the others
    tap_nine_sign_a: assert property (
        (a_wr && idx == `EQF_IDX_A_TAP9)
        |=> a_vec[8] == 18'($signed($past(apb_i.pwdata[11:0]))))
        else $error("tap nine not 12-bit signed");

    // The control word picks the mode on the write edge itself
    mode_write_a: assert property (
        (wr_stb && ctrl_hit)
        |=> mode == eqf_mode_type'($past(apb_i.pwdata[`EQF_CTRL_SINGLE])))
        else $error("mode write lost");

    // Status is read-only; a write there must change nothing
    stat_ro_a: assert property (
        (wr_stb && stat_hit) |=> $stable(mode) && $stable(a_vec))
        else $error("status write changed state");

    // A refused access must leave every coefficient untouched
    refused_drop_a: assert property (
        apb_o.pslverr |=> $stable(a_vec) && $stable(b_vec))
        else $error("refused access changed a coefficient");

    // Read path returns the stored tap six image, reserved bits too
    read_tap_six_a: assert property (
        (a_rd && idx == `EQF_IDX_A_TAP6)
        |=> apb_o.prdata == {8'h00, $past(coef_a[5])})
        else $error("tap six read back wrong");

    // Dual mode hands the B filter its own center tap
    b_center_a: assert property (
        (b_wr && mode == EQF_DUAL && dec.tap == `EQF_CENTER_TAP)
        |=> b_use[4] == $signed($past(apb_i.pwdata[17:0])))
        else $error("set B center not on filter B");

    // Dual mode hands the B filter its own last tap
    b_tap_nine_a: assert property (
        (b_wr && mode == EQF_DUAL && dec.tap == 4'h8)
        |=> b_use[8] == 18'($signed($past(apb_i.pwdata[11:0]))))
        else $error("set B tap nine not on filter B");

    // Output strobe of filter A appears only after an input sample, never on its own
    a_quiet_a: assert property (
        !smp_a_i.valid |=> !acc_a_o.valid)
        else $error("filter A strobe without sample");

    cov_center_wr: cover property (a_wr && idx == `EQF_IDX_A_CENTER);
    cov_b_dual:    cover property (b_wr && mode == EQF_DUAL);
    cov_single:    cover property (mode == EQF_SINGLE && smp_b_i.valid);
    cov_slverr:    cover property (apb_o.pslverr);
    cov_filter:    cover property (acc_a_o.valid && acc_a_o.data != 0);

endmodule : eqf_top

// [tb_top.sv]
// Purpose: Self-checking bench for the equalizer FIR coefficient store
// Assumes: APB slave on clock_i; one stream sample every other cycle
// Notes:   Expected sums come from the written words, never from outputs
`timescale 1ns/1ps
`include "eqf_regs.svh"
module tb_top
    import eqf_pkg::*;
();
    // Channel A register indices, tap one first
    localparam logic [13:0] IA [9] = '{`EQF_IDX_A_TAP1, `EQF_IDX_A_TAP2,
        `EQF_IDX_A_TAP3, `EQF_IDX_A_TAP4, `EQF_IDX_A_CENTER, `EQF_IDX_A_TAP6,
        `EQF_IDX_A_TAP7, `EQF_IDX_A_TAP8, `EQF_IDX_A_TAP9};
    // Words with reserved bits set, both signs and the 12-bit extremes
    localparam logic [31:0] WA [9] = '{32'h0000A801, 32'h000050F2,
        32'hFFFFA803, 32'h000057FF, 32'hFFE2ABCD, 32'h0000F806,
        32'h00003107, 32'h0000A800, 32'h0000C009};

    // Design ports
    logic            clock_i;
    logic            rst_n_i;
    eqf_apb_req_type apb_i;
    eqf_apb_rsp_type apb_o;
    eqf_smp_type     smp_a_i;
    eqf_smp_type     smp_b_i;
    eqf_acc_type     acc_a_o;
    eqf_acc_type     acc_b_o;
    eqf_mode_type    mode_o;
    // Bench state
    int                 fails;      // Mismatches seen
    int                 num_checks; // Comparisons made
    logic [31:0]        rd;         // Last read data
    logic               err;        // Last slave error
    logic signed [31:0] ca [10];    // Expected taps of filter A, 10th is 0
    logic signed [31:0] cb [10];    // Expected taps of filter B, 10th is 0

    eqf_top eqf_top_inst (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .apb_i   (apb_i),
        .apb_o   (apb_o),
        .smp_a_i (smp_a_i),
        .acc_a_o (acc_a_o),
        .smp_b_i (smp_b_i),
        .acc_b_o (acc_b_o),
        .mode_o  (mode_o)
    );

    // 25 MHz clock
    always #20 clock_i = ~clock_i;

    // Word compare, four-state exact
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    // Flag compare, an unknown never matches
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    // Counts, verdict and end of run
    task automatic print_verdict;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb_xfer(input logic wr, input logic [15:0] addr,
                            input logic [31:0] wdata,
                            output logic [31:0] rdata, output logic slverr);
        int n;
        @(posedge clock_i);
        apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr,
                   pwdata: wdata};
        @(posedge clock_i);
        apb_i.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (apb_o.pready !== 1'b1 && n < 50);
        // Answer is taken at the very edge that saw pready
        rdata = apb_o.prdata;
        slverr = apb_o.pslverr;
        apb_i <= '0;
        // A slave that never answers ends the run as a failure
        if (n >= 50) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            print_verdict();
        end
    endtask : apb_xfer

    // Register write by word index
    task automatic reg_wr(input logic [13:0] idx, input logic [31:0] d);
        apb_xfer(1'b1, {idx, 2'b00}, d, rd, err);
    endtask : reg_wr

    // Register read by word index, result in rd
    task automatic reg_rd(input logic [13:0] idx);
        apb_xfer(1'b0, {idx, 2'b00}, 32'h00000000, rd, err);
    endtask : reg_rd

    // Field value the filter should use, sign-extended
    function automatic logic signed [31:0] coef_of(input logic [31:0] w,
                                                   input bit ctr);
        if (ctr) return {{14{w[17]}}, w[17:0]};
        return {{20{w[11]}}, w[11:0]};
    endfunction : coef_of

    // One sample on both channels; returns where the output is settled
    task automatic push(input logic signed [7:0] xa,
                        input logic signed [7:0] xb);
        @(posedge clock_i);
        smp_a_i <= '{valid: 1'b1, data: xa};
        smp_b_i <= '{valid: 1'b1, data: xb};
        @(posedge clock_i);
        smp_a_i.valid <= 1'b0;
        smp_b_i.valid <= 1'b0;
        #1;
    endtask : push

    // Scaled impulse then zeros: output n shows tap n+1 times the impulse
    task automatic impulse(input logic signed [7:0] xa,
                           input logic signed [7:0] xb);
        logic signed [31:0] ea;
        logic signed [31:0] eb;
        for (int n = 0; n < 10; n++) begin
            push(n == 0 ? xa : 8'sh00, n == 0 ? xb : 8'sh00);
            ea = xa * ca[n];
            eb = xb * cb[n];
            chk_bit(acc_a_o.valid, 1'b1);
            chk_bit(acc_b_o.valid, 1'b1);
            if (n == 4) chk_word(acc_a_o.data, ea);
            else if (n < 4) chk_word(acc_a_o.data, ea);
            else chk_word(acc_a_o.data, ea);
            chk_word(acc_b_o.data, eb);
        end
        // Output strobes last one cycle only
        @(posedge clock_i);
        #1;
        chk_bit(acc_a_o.valid, 1'b0);
        chk_bit(acc_b_o.valid, 1'b0);
    endtask : impulse

    // Watchdog, far beyond the under 200 cycles the tests take
    initial begin
        #(40 * 20000);
        fails++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        print_verdict();
    end

    // Main sequence
    initial begin
        clock_i = 1'b0;
        rst_n_i = 1'b0;
        apb_i = '0;
        smp_a_i = '0;
        smp_b_i = '0;
        fails = 0;
        num_checks = 0;
        for (int k = 0; k < 10; k++) begin
            ca[k] = 32'sh0;
            cb[k] = 32'sh0;
        end
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        // Reset state of the A set and of the mode
        for (int k = 0; k < 9; k++) begin
            reg_rd(IA[k]);
            chk_word(rd, 32'h00000000);
        end
        chk_bit(mode_o, 1'b0);
        // Write each A word and read back only the stored width
        for (int k = 0; k < 9; k++) begin
            reg_wr(IA[k], WA[k]);
            reg_rd(IA[k]);
            if (k == 4) chk_word(rd, WA[k] & 32'h00FFFFFF);
            else chk_word(rd, WA[k] & 32'h0000FFFF);
            ca[k] = coef_of(WA[k], k == 4);
        end
        // Gap index and misaligned accesses are refused and dropped
        apb_xfer(1'b0, {14'h0421, 2'b00}, 32'h00000000, rd, err);
        chk_bit(err, 1'b1);
        chk_word(rd, 32'h00000000);
        apb_xfer(1'b1, 16'h108E, 32'h00000000, rd, err);
        chk_bit(err, 1'b1);
        reg_rd(`EQF_IDX_A_TAP6);
        chk_word(rd, WA[5] & 32'h0000FFFF);
        // Dual mode: B runs on its own sparse set
        reg_wr(`EQF_IDX_B_CENTER, 32'h00000007);
        reg_wr(`EQF_IDX_B_TAP9, 32'h0000FFFE);
        cb[4] = 32'sh7;
        cb[8] = -32'sh2;
        impulse(-8'sh02, 8'sh03);
        // Single mode: the shared filter runs on the A set
        reg_wr(`EQF_IDX_CTRL, 32'h00000001);
        // The mode flop takes the word on the access edge; look just after
        #1;
        chk_bit(mode_o, 1'b1);
        reg_rd(`EQF_IDX_CTRL);
        chk_word(rd, 32'h00000001);
        cb = ca;
        impulse(8'sh05, -8'sh01);
        // Status shows the last channel A output; writes leave it alone
        push(8'sh01, 8'sh00);
        chk_word(acc_a_o.data, ca[0]);
        reg_wr(`EQF_IDX_STAT, 32'h0000FFFF);
        chk_bit(err, 1'b0);
        reg_rd(`EQF_IDX_STAT);
        chk_word(rd, ca[0]);
        chk_bit(mode_o, 1'b1);
        // Reset in mid-run clears every coefficient and the mode
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        reg_rd(`EQF_IDX_A_CENTER);
        chk_word(rd, 32'h00000000);
        chk_bit(mode_o, 1'b0);
        for (int k = 0; k < 10; k++) begin
            ca[k] = 32'sh0;
            cb[k] = 32'sh0;
        end
        impulse(8'sh07, 8'sh07);
        print_verdict();
    end
endmodule : tb_top
